// ### rtl/dcl_ctrl.sv
// dcl_ctrl: clear value, software pulses, output state and
// amplifier configuration of an 18-bit serial dac.
// assumes: host writes 24-bit frames, load/clear pins async.
//
// Contract
// R1: clear register holds 18 bits from frame 19..2, used on clear.
// R2: clear value is read in the currently selected code format.
// R3: clear register is zero after reset.
// R4: software pulse register is write only, one acts as a pin pulse.
// R5: software clear ignored while load pin is low.
// R6: software load ignored while clear pin is low.
// R7: software load moves pending data to the dac register.
// R8: software clear copies clear value into the dac register.
// R9: software reset bit returns the device to power-on state.
// R10: power-on reset sets every register to its default.
// R11: after reset output floats and is clamped until control write.
// R12: host clears float and clamp bits before programming output.
// R13: released without dac write, output sits at negative reference.
// R14: clamp wins, float alone floats, both clear is normal.
// R15: host sets linearity field 0000 up to 10 v, 1100 for 20 v.
// R16: linearity field resets to 0000.
// R17: feedback select one puts resistors in parallel.
// R18: feedback select zero puts resistors in series.
// R19: format bit zero twos complement default, one offset binary.
// R20: float bit resets to one.
// R21: 24-bit frames, bit 23 read flag, bits 22..20 address.
`timescale 1ns/1ps
`default_nettype none
module dcl_ctrl
  import dcl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdin,
  input  wire logic        load_output_n,
  input  wire logic        clear_to_code_n,
  output var  logic [17:0] dac_code,
  output var  logic [17:0] dac_level,
  output var  logic [1:0]  out_mode,
  output var  logic        output_float_ctl,
  output var  logic        ground_clamp_ctl,
  output var  logic        feedback_resistor_sel,
  output var  logic        code_format_sel,
  output var  logic [3:0]  lin_comp
);

  ////////////////////////////////////////////////////////////
  // link side

  logic [FRAME_W-1:0] word_q;
  logic               word_tog_q;

  dcl_serial_rx u_rx (
    .sclk       (sclk),
    .sys_rst    (sys_rst),
    .sync_n     (sync_n),
    .sdin       (sdin),
    .word_q     (word_q),
    .word_tog_q (word_tog_q)
  );

  ////////////////////////////////////////////////////////////
  // crossings and pin synchronisers

  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic ld_s1_q;
  logic ld_s2_q;
  logic ld_prev_q;
  logic cl_s1_q;
  logic cl_s2_q;
  logic cl_prev_q;

  // word_q is held until the next frame ends, far longer
  // than the three cycles the toggle needs to arrive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tog_s1_q <= 1'h0;
      tog_s2_q <= 1'h0;
      tog_s3_q <= 1'h0;
    end else begin
      tog_s1_q <= word_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ld_s1_q   <= 1'h1;
      ld_s2_q   <= 1'h1;
      ld_prev_q <= 1'h1;
      cl_s1_q   <= 1'h1;
      cl_s2_q   <= 1'h1;
      cl_prev_q <= 1'h1;
    end else begin
      ld_s1_q   <= load_output_n;
      ld_s2_q   <= ld_s1_q;
      ld_prev_q <= ld_s2_q;
      cl_s1_q   <= clear_to_code_n;
      cl_s2_q   <= cl_s1_q;
      cl_prev_q <= cl_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // frame decode

  logic       frame_stb;
  logic       wr_stb;
  logic [2:0] addr;
  logic       wr_dac;
  logic       wr_ctrl;
  logic       wr_clear;
  logic       wr_swctl;
  logic       sw_load;
  logic       sw_clear;
  logic       sw_reset;
  logic       pin_load;
  logic       pin_clear;
  logic       any_clear;
  logic       any_load;

  assign frame_stb = tog_s2_q ^ tog_s3_q;
  // R21: read flag and address
  assign wr_stb   = frame_stb & ~word_q[RW_BIT];
  assign addr     = word_q[ADDR_HI:ADDR_LO];
  assign wr_dac   = wr_stb & (addr == ADDR_DAC);
  assign wr_ctrl  = wr_stb & (addr == ADDR_CTRL);
  assign wr_clear = wr_stb & (addr == ADDR_CLEAR);
  assign wr_swctl = wr_stb & (addr == ADDR_SWCTL);

  // R4: ones act as pin pulses
  assign sw_reset = wr_swctl & word_q[SW_RESET_BIT];
  // R5: clear blocked by low load pin
  assign sw_clear = wr_swctl & word_q[SW_CLEAR_BIT] & ld_s2_q;
  // R6: load blocked by low clear pin
  assign sw_load  = wr_swctl & word_q[SW_LOAD_BIT] & cl_s2_q;

  assign pin_load  = ld_prev_q & ~ld_s2_q;
  assign pin_clear = cl_prev_q & ~cl_s2_q;
  assign any_clear = pin_clear | sw_clear;
  assign any_load  = pin_load | sw_load;

  ////////////////////////////////////////////////////////////
  // software reset

  logic soft_rst_q;
  logic rst_all;

  // R9: one-cycle internal power-on reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst_q <= 1'h0;
    end else begin
      soft_rst_q <= sw_reset;
    end
  end

  assign rst_all = sys_rst | soft_rst_q;

  ////////////////////////////////////////////////////////////
  // clear value and pending data

  logic [17:0] clear_q;
  logic [17:0] input_q;

  // R1: clear value field
  // R3: zero after reset
  always_ff @(posedge clk) begin
    if (rst_all) begin
      clear_q <= CODE_RST;
    end else if (wr_clear) begin
      clear_q <= word_q[DATA_HI:DATA_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      input_q <= CODE_RST;
    end else if (wr_dac) begin
      input_q <= word_q[DATA_HI:DATA_LO];
    end
  end

  ////////////////////////////////////////////////////////////
  // dac register

  logic [17:0] dac_q;
  logic        dac_valid_q;

  // clear outranks load when both land in one cycle;
  // a data write with the load pin held low goes straight in
  always_ff @(posedge clk) begin
    if (rst_all) begin
      dac_q       <= CODE_RST;
      dac_valid_q <= 1'h0;
    end else if (any_clear) begin
      // R8: clear copies clear value
      dac_q       <= clear_q;
      dac_valid_q <= 1'h1;
    end else if (any_load) begin
      // R7: load moves pending data
      dac_q       <= input_q;
      dac_valid_q <= 1'h1;
    end else if (wr_dac && !ld_s2_q) begin
      dac_q       <= word_q[DATA_HI:DATA_LO];
      dac_valid_q <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  // control register

  logic       float_q;
  logic       clamp_q;
  logic       fb_q;
  logic       fmt_q;
  logic [3:0] lin_q;

  // R10: every field to default
  // R11: float and clamp until written
  // R16: linearity field default
  // R20: float defaults to one
  always_ff @(posedge clk) begin
    if (rst_all) begin
      float_q <= FLOAT_RST;
      clamp_q <= CLAMP_RST;
      fb_q    <= FB_RST;
      fmt_q   <= FMT_RST;
      lin_q   <= LIN_RST;
    end else if (wr_ctrl) begin
      float_q <= word_q[CTL_FLOAT_BIT];
      clamp_q <= word_q[CTL_CLAMP_BIT];
      fb_q    <= word_q[CTL_FB_BIT];
      fmt_q   <= word_q[CTL_FMT_BIT];
      lin_q   <= word_q[CTL_LIN_HI:CTL_LIN_LO];
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs

  dcl_out_mode_t mode_d;
  dcl_out_mode_t mode_q;
  logic [17:0]   level_d;
  logic [17:0]   level_q;

  // R14: clamp wins over float
  always_comb begin
    if (clamp_q) begin
      mode_d = DCL_CLAMP;
    end else if (float_q) begin
      mode_d = DCL_FLOAT;
    end else begin
      mode_d = DCL_NORMAL;
    end
  end

  // level is offset binary: zero is the negative reference
  // R2: clear value read in current format
  // R13: unwritten register gives negative reference
  // R19: zero selects twos complement
  always_comb begin
    if (!dac_valid_q) begin
      level_d = CODE_RST;
    end else if (fmt_q) begin
      level_d = dac_q;
    end else begin
      level_d = dac_q ^ CODE_MSB;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q  <= DCL_CLAMP;
      level_q <= CODE_RST;
    end else begin
      mode_q  <= mode_d;
      level_q <= level_d;
    end
  end

  // R17: one puts resistors in parallel
  // R18: zero puts resistors in series
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_code              <= CODE_RST;
      output_float_ctl      <= FLOAT_RST;
      ground_clamp_ctl      <= CLAMP_RST;
      feedback_resistor_sel <= FB_RST;
      code_format_sel       <= FMT_RST;
      lin_comp              <= LIN_RST;
    end else begin
      dac_code              <= dac_q;
      output_float_ctl      <= float_q;
      ground_clamp_ctl      <= clamp_q;
      feedback_resistor_sel <= fb_q;
      code_format_sel       <= fmt_q;
      lin_comp              <= lin_q;
    end
  end

  assign dac_level = level_q;
  assign out_mode  = mode_q;

  ////////////////////////////////////////////////////////////
  // assertions

  a_clear_value_reset: assert property ( // R3
    @(posedge clk) disable iff (sys_rst)
    soft_rst_q |=> (clear_q == CODE_RST))
    else $error("clear value not zero after reset");

  a_clear_copies_code: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    (any_clear && !rst_all) |=> (dac_q == $past(clear_q)) ##1
    (dac_code == $past(clear_q, 2)))
    else $error("clear did not copy clear value");

  a_sw_load_xfer: assert property ( // R7
    @(posedge clk) disable iff (sys_rst)
    (sw_load && !any_clear && !rst_all) |=>
    (dac_q == $past(input_q)) && dac_valid_q)
    else $error("software load did not move data");

  a_sw_clear_block: assert property ( // R5
    @(posedge clk) disable iff (sys_rst)
    (wr_swctl && word_q[SW_CLEAR_BIT] && !ld_s2_q
     && !pin_clear) |-> !any_clear)
    else $error("software clear acted with load low");

  a_sw_load_block: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    (!cl_s2_q && !pin_load) |-> !any_load)
    else $error("software load acted with clear low");

  a_reset_clamped: assert property ( // R11
    @(posedge clk) disable iff (sys_rst)
    soft_rst_q |=> (float_q && clamp_q && !wr_ctrl)[*1] ##1
    (mode_q == DCL_CLAMP) ##1 output_float_ctl)
    else $error("reset did not float and clamp");

  a_mode_decode: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    (float_q && !clamp_q) |=> (mode_q == DCL_FLOAT))
    else $error("float alone not decoded");

  a_negref_unwritten: assert property ( // R13
    @(posedge clk) disable iff (sys_rst)
    !dac_valid_q |=> (level_q == CODE_RST))
    else $error("unwritten level not at negative reference");

  a_soft_reset_all: assert property ( // R9
    @(posedge clk) disable iff (sys_rst)
    sw_reset |=> soft_rst_q ##1
    (lin_q == LIN_RST && fb_q && !fmt_q && !dac_valid_q))
    else $error("software reset did not restore defaults");

  a_twos_format: assert property ( // R2
    @(posedge clk) disable iff (sys_rst)
    (dac_valid_q && !fmt_q) |=>
    (level_q == ($past(dac_q) ^ CODE_MSB)))
    else $error("twos complement level wrong");

  a_fb_follows: assert property ( // R17
    @(posedge clk) disable iff (sys_rst)
    (wr_ctrl && !rst_all) |=> ##1
    (feedback_resistor_sel == $past(word_q[CTL_FB_BIT], 2)))
    else $error("feedback select not applied");

endmodule
`default_nettype wire

// ### rtl/dcl_pkg.sv
// dcl_pkg: frame layout, register addresses, field positions
// and reset values of the dac clear/load/output control block.
// assumes: 24-bit serial frames, msb first.
package dcl_pkg;

  // frame layout
  localparam int          FRAME_W    = 24;
  localparam logic [4:0]  FRAME_BITS = 5'h18;
  localparam logic [4:0]  LAST_BIT   = 5'h17;
  localparam int          RW_BIT     = 23;
  localparam int          ADDR_HI    = 22;
  localparam int          ADDR_LO    = 20;
  localparam int          DATA_HI    = 19;
  localparam int          DATA_LO    = 2;
  localparam int          CODE_W     = 18;

  // register addresses
  localparam logic [2:0]  ADDR_DAC   = 3'h1;
  localparam logic [2:0]  ADDR_CTRL  = 3'h2;
  localparam logic [2:0]  ADDR_CLEAR = 3'h3;
  localparam logic [2:0]  ADDR_SWCTL = 3'h4;

  // software pulse control bits
  localparam int          SW_LOAD_BIT  = 0;
  localparam int          SW_CLEAR_BIT = 1;
  localparam int          SW_RESET_BIT = 2;

  // control register bits
  localparam int          CTL_FB_BIT    = 1;
  localparam int          CTL_FLOAT_BIT = 2;
  localparam int          CTL_CLAMP_BIT = 3;
  localparam int          CTL_FMT_BIT   = 4;
  localparam int          CTL_LIN_LO    = 6;
  localparam int          CTL_LIN_HI    = 9;

  // reset values and code msb mask
  localparam logic [17:0] CODE_RST   = 18'h0_0000;
  localparam logic [17:0] CODE_MSB   = 18'h2_0000;
  localparam logic [3:0]  LIN_RST    = 4'h0;
  localparam logic        FB_RST     = 1'h1;
  localparam logic        FLOAT_RST  = 1'h1;
  localparam logic        CLAMP_RST  = 1'h1;
  localparam logic        FMT_RST    = 1'h0;

  typedef enum logic [1:0] {
    DCL_NORMAL = 2'h0,
    DCL_CLAMP  = 2'h1,
    DCL_FLOAT  = 2'h2
  } dcl_out_mode_t;

endpackage

// ### rtl/dcl_serial_rx.sv
// dcl_serial_rx: link-side frame receiver on the serial clock.
// assumes: sync_n frames each write, sdin valid at sclk rise;
// sclk may stop between frames, so no logic needs a late edge.
`timescale 1ns/1ps
`default_nettype none
module dcl_serial_rx
  import dcl_pkg::*;
(
  input  wire logic               sclk,
  input  wire logic               sys_rst,
  input  wire logic               sync_n,
  input  wire logic               sdin,
  output var  logic [FRAME_W-1:0] word_q,
  output var  logic               word_tog_q
);

  logic [4:0]         cnt_q;
  logic [FRAME_W-2:0] sh_q;

  // frame end clears the count without any sclk edge
  always_ff @(posedge sclk or posedge sync_n) begin
    if (sync_n) begin
      cnt_q <= 5'h0;
    end else if (cnt_q != FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h1;
    end
  end

  always_ff @(posedge sclk) begin
    if (!sync_n && cnt_q != FRAME_BITS) begin
      sh_q <= {sh_q[FRAME_W-3:0], sdin};
    end
  end

  // R21: capture frame
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q     <= 24'h00_0000;
      word_tog_q <= 1'h0;
    end else if (!sync_n && cnt_q == LAST_BIT) begin
      word_q     <= {sh_q, sdin};
      word_tog_q <= ~word_tog_q;
    end
  end

endmodule
`default_nettype wire

// ### tb/dcl_host_model.sv
// dcl_host_model: host side of the three-wire link, msb-first writer.
// assumes: caller invokes send_frame from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module dcl_host_model (
  output var logic sclk,
  output var logic sync_n,
  output var logic sdin
);
  localparam time HALF = 24ns;

  initial begin
    sclk   = 1'h0;
    sync_n = 1'h1;
    sdin   = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // gap sets idle halves after a frame, so a slow host can be modelled
  // 24-bit framed write
  task automatic send_frame(input logic [23:0] w, input int gap);
    int i;
    sync_n = 1'h0;
    for (i = 23; i >= 0; i--) begin
      sdin = w[i];
      #HALF sclk = 1'h1;
      #HALF sclk = 1'h0;
    end
    // released line shows the inverse so a late sample cannot look valid
    sdin = ~sdin;
    #HALF sync_n = 1'h1;
    #(HALF * gap);
  endtask
endmodule
`default_nettype wire

// ### tb/dac_clear_load_output_control_test.sv
// dac_clear_load_output_control_test: register-level bench for dcl_ctrl.
// assumes: dcl_pkg compiled first, dcl_host_model drives the link.
`timescale 1ns/1ps
`default_nettype none
module dac_clear_load_output_control_test;
  import dcl_pkg::*;

  `define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end

  logic        clk;
  logic        sys_rst;
  logic        load_output_n;
  logic        clear_to_code_n;
  wire         sclk;
  wire         sync_n;
  wire         sdin;
  logic [17:0] dac_code;
  logic [17:0] dac_level;
  logic [1:0]  out_mode;
  logic        output_float_ctl;
  logic        ground_clamp_ctl;
  logic        feedback_resistor_sel;
  logic        code_format_sel;
  logic [3:0]  lin_comp;
  logic [1:0]  em;
  int          failures;
  int          samples_checked;
  int          cycles;
  int          i;

  dcl_ctrl dcl_ctrl_inst (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .sclk                 (sclk),
    .sync_n               (sync_n),
    .sdin                 (sdin),
    .load_output_n        (load_output_n),
    .clear_to_code_n      (clear_to_code_n),
    .dac_code             (dac_code),
    .dac_level            (dac_level),
    .out_mode             (out_mode),
    .output_float_ctl     (output_float_ctl),
    .ground_clamp_ctl     (ground_clamp_ctl),
    .feedback_resistor_sel(feedback_resistor_sel),
    .code_format_sel      (code_format_sel),
    .lin_comp             (lin_comp)
  );

  dcl_host_model dcl_host_model_inst (
    .sclk  (sclk),
    .sync_n(sync_n),
    .sdin  (sdin)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // crossing and output registers take a few clk edges; 12 leaves margin for sw reset
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [19:0] d);
    dcl_host_model_inst.send_frame({1'h0, a, d}, 2);
    settle();
  endtask

  task automatic wr_code(input logic [2:0] a, input logic [17:0] c);
    wr(a, {c, 2'h0});
  endtask

  task automatic sw(input logic [2:0] bits);
    wr(ADDR_SWCTL, {17'h0_0000, bits});
  endtask

  task automatic ctl(input logic fb, input logic fl, input logic cl, input logic fmt, input logic [3:0] lin);
    logic [19:0] d;
    d = 20'h0_0000;
    d[CTL_FB_BIT] = fb;
    d[CTL_FLOAT_BIT] = fl;
    d[CTL_CLAMP_BIT] = cl;
    d[CTL_FMT_BIT] = fmt;
    d[CTL_LIN_HI:CTL_LIN_LO] = lin;
    wr(ADDR_CTRL, d);
  endtask

  task automatic chk_defaults();
    `CHK("out_mode", 2'h1, out_mode)
    `CHK("float", FLOAT_RST, output_float_ctl)
    `CHK("clamp", CLAMP_RST, ground_clamp_ctl)
    `CHK("fb_sel", FB_RST, feedback_resistor_sel)
    `CHK("format", FMT_RST, code_format_sel)
    `CHK("lin", LIN_RST, lin_comp)
    `CHK("dac_code", CODE_RST, dac_code)
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cycles = 0;
    failures = 0;
    samples_checked = 0;
    sys_rst = 1'h1;
    load_output_n = 1'h1;
    clear_to_code_n = 1'h1;
    repeat (6) @(negedge clk);
    sys_rst = 1'h0;
    @(negedge clk);
    chk_defaults();
    for (i = 0; i < 4; i++) begin
      ctl(1'h1, i[1], i[0], 1'h0, 4'hc);
      em = i[0] ? DCL_CLAMP : (i[1] ? DCL_FLOAT : DCL_NORMAL);
      `CHK("out_mode", em, out_mode)
      `CHK("float", i[1], output_float_ctl)
      `CHK("clamp", i[0], ground_clamp_ctl)
      `CHK("lin", 4'hc, lin_comp)
    end
    // host releases float and clamp before any output value
    ctl(1'h0, 1'h0, 1'h0, 1'h0, 4'h0);
    `CHK("fb_sel", 1'h0, feedback_resistor_sel)
    `CHK("out_mode", 2'h0, out_mode)
    `CHK("dac_level", 18'h0_0000, dac_level)
    ctl(1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
    `CHK("fb_sel", 1'h1, feedback_resistor_sel)
    // low two bits are don't care and must not reach the clear value
    wr(ADDR_CLEAR, {18'h1_2345, 2'h3});
    sw(3'h2);
    `CHK("dac_code", 18'h1_2345, dac_code)
    `CHK("dac_level", 18'h1_2345 ^ CODE_MSB, dac_level)
    ctl(1'h1, 1'h0, 1'h0, 1'h1, 4'h0);
    `CHK("format", 1'h1, code_format_sel)
    sw(3'h2);
    `CHK("dac_level", 18'h1_2345, dac_level)
    wr_code(ADDR_DAC, 18'h0_0abc);
    `CHK("dac_code", 18'h1_2345, dac_code)
    sw(3'h1);
    `CHK("dac_code", 18'h0_0abc, dac_code)
    load_output_n = 1'h0;
    settle();
    sw(3'h2);
    `CHK("dac_code", 18'h0_0abc, dac_code)
    load_output_n = 1'h1;
    settle();
    // a read frame must not overwrite the clear value
    dcl_host_model_inst.send_frame({1'h1, ADDR_CLEAR, 18'h3_ffff, 2'h0}, 40);
    settle();
    wr_code(ADDR_DAC, 18'h0_1111);
    clear_to_code_n = 1'h0;
    settle();
    `CHK("dac_code", 18'h1_2345, dac_code)
    sw(3'h1);
    `CHK("dac_code", 18'h1_2345, dac_code)
    clear_to_code_n = 1'h1;
    settle();
    sw(3'h1);
    `CHK("dac_code", 18'h0_1111, dac_code)
    sw(3'h4);
    chk_defaults();
    wr_code(ADDR_DAC, 18'h2_aaaa);
    sw(3'h1);
    `CHK("dac_code", 18'h2_aaaa, dac_code)
    sw(3'h2);
    `CHK("dac_code", 18'h0_0000, dac_code)
    tally_and_finish();
  end
endmodule
`default_nettype wire
